// ===== logic/ifp_pkg.sv
`default_nettype none
package ifp_pkg;

	// ----------------------------------------------------------------
	// Sizes and types
	// ----------------------------------------------------------------
	localparam int IFP_NUM_SRC = 18;
	localparam int IFP_NUM_GRP = 6;
	localparam int IFP_NUM_LVL = 4;

	typedef logic [4:0] ifp_src_t;
	typedef logic [1:0] ifp_level_t;
	typedef logic [7:0] ifp_byte_t;

	// ----------------------------------------------------------------
	// Register offsets, masks and reset values
	// ----------------------------------------------------------------
	localparam ifp_byte_t IFP_OFS_PRIO_LOW = 8'ha9;
	localparam ifp_byte_t IFP_OFS_PRIO_HIGH = 8'hb9;
	localparam ifp_byte_t IFP_OFS_FLAGS_FOUR = 8'hc0;
	localparam ifp_byte_t IFP_OFS_FLAGS_FIVE = 8'he8;
	localparam ifp_byte_t IFP_MASK_FLAGS_FOUR = 8'hbf;
	localparam ifp_byte_t IFP_MASK_FLAGS_FIVE = 8'h1f;
	localparam logic [5:0] IFP_RST_PRIO = 6'h00;
	localparam ifp_byte_t IFP_RST_FLAGS = 8'h00;
	localparam ifp_byte_t IFP_READ_IDLE = 8'h00;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int IFP_BIT_SLEEP = 7;
	localparam int IFP_BIT_PORT0 = 5;
	localparam int IFP_BIT_TIMER4 = 4;
	localparam int IFP_BIT_TIMER3 = 3;
	localparam int IFP_BIT_TIMER2 = 2;
	localparam int IFP_BIT_TIMER1 = 1;
	localparam int IFP_BIT_XFER = 0;
	localparam int IFP_BIT_WDOG = 4;
	localparam int IFP_BIT_PORT1 = 3;
	localparam int IFP_BIT_STX1 = 2;
	localparam int IFP_BIT_STX0 = 1;
	localparam int IFP_BIT_PORT2 = 0;

	// ----------------------------------------------------------------
	// Source numbers
	// ----------------------------------------------------------------
	localparam ifp_src_t IFP_SRC_RADIO_FIFO_ERROR_SOURCE = 5'h00;
	localparam ifp_src_t IFP_SRC_CONV = 5'h01;
	localparam ifp_src_t IFP_SRC_SRX0 = 5'h02;
	localparam ifp_src_t IFP_SRC_SRX1 = 5'h03;
	localparam ifp_src_t IFP_SRC_CIPHER = 5'h04;
	localparam ifp_src_t IFP_SRC_SLEEP = 5'h05;
	localparam ifp_src_t IFP_SRC_PORT2 = 5'h06;
	localparam ifp_src_t IFP_SRC_STX0 = 5'h07;
	localparam ifp_src_t IFP_SRC_XFER = 5'h08;
	localparam ifp_src_t IFP_SRC_TIMER1 = 5'h09;
	localparam ifp_src_t IFP_SRC_TIMER2 = 5'h0a;
	localparam ifp_src_t IFP_SRC_TIMER3 = 5'h0b;
	localparam ifp_src_t IFP_SRC_TIMER4 = 5'h0c;
	localparam ifp_src_t IFP_SRC_PORT0 = 5'h0d;
	localparam ifp_src_t IFP_SRC_STX1 = 5'h0e;
	localparam ifp_src_t IFP_SRC_PORT1 = 5'h0f;
	localparam ifp_src_t IFP_SRC_RADIO = 5'h10;
	localparam ifp_src_t IFP_SRC_WDOG = 5'h11;

	// Fixed polling order, first entry wins a tie
	localparam ifp_src_t IFP_POLL_ORDER [IFP_NUM_SRC] = '{
		5'h00, 5'h10, 5'h08, 5'h01, 5'h09, 5'h02, 5'h0a, 5'h03, 5'h0b,
		5'h04, 5'h0c, 5'h05, 5'h0d, 5'h06, 5'h07, 5'h0e, 5'h0f, 5'h11};

	// Priority group of each source, indexed by source number
	localparam logic [2:0] IFP_SRC_GROUP [IFP_NUM_SRC] = '{
		3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h1, 3'h2, 3'h0,
		3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h3, 3'h4, 3'h0, 3'h5};

	// ----------------------------------------------------------------
	// Timing in machine cycles
	// ----------------------------------------------------------------
	localparam int IFP_DETECT_CYCLES = 1;
	localparam int IFP_CALL_CYCLES = 6;
	localparam int IFP_RESPONSE_CYCLES = IFP_DETECT_CYCLES + IFP_CALL_CYCLES;
	localparam logic [2:0] IFP_CALL_LOAD = 3'(IFP_CALL_CYCLES);

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic sleepTimer;
		logic portZero;
		logic timerFour;
		logic timerThree;
		logic timerTwo;
		logic timerOne;
		logic transferDone;
		logic watchdog;
		logic portOne;
		logic serialOneTx;
		logic serialZeroTx;
		logic portTwo;
	} ifp_set_s;

	typedef struct packed {
		logic radioFifoError;
		logic radioGeneral;
		logic converter;
		logic serialZeroRx;
		logic serialOneRx;
		logic cipher;
	} ifp_outside_s;

	typedef struct packed {
		logic valid;
		ifp_src_t number;
		ifp_level_t level;
	} ifp_req_s;

	// Pair decode, high bit first
	function automatic ifp_level_t ifp_decode_level(input logic hi, input logic lo);
		return {hi, lo};
	endfunction

endpackage
`default_nettype wire

// ===== logic/ifp_poll_arbiter.sv
`timescale 1ns/100ps
`default_nettype none
module ifp_poll_arbiter (
	input wire logic [ifp_pkg::IFP_NUM_SRC-1:0] pending, // Pending vector by source
	input wire logic [ifp_pkg::IFP_NUM_GRP-1:0] prioHigh, // Group high bits
	input wire logic [ifp_pkg::IFP_NUM_GRP-1:0] prioLow, // Group low bits
	input wire logic serviceActive, // A routine is running
	input wire ifp_pkg::ifp_level_t serviceLevel, // Level in service
	output ifp_pkg::ifp_req_s winner // Selected request
);
	import ifp_pkg::*;

	// ----------------------------------------------------------------
	// Group levels
	// ----------------------------------------------------------------
	ifp_level_t groupLevel [IFP_NUM_GRP];

	for (genvar g = 0; g < IFP_NUM_GRP; g++) begin : g_lvl
		assign groupLevel[g] = ifp_decode_level(prioHigh[g], prioLow[g]);
	end

	// ----------------------------------------------------------------
	// Selection
	// ----------------------------------------------------------------
	always_comb begin
		ifp_src_t src;
		ifp_level_t lv;
		logic eligible;
		src = '0;
		lv = '0;
		eligible = 1'b0;
		winner = '0;
		for (int i = 0; i < IFP_NUM_SRC; i++) begin
			src = IFP_POLL_ORDER[i];
			lv = groupLevel[IFP_SRC_GROUP[src]];
			// Only strictly higher than the running level may go
			eligible = pending[src] && (!serviceActive || (lv > serviceLevel));
			// Strict compare keeps the earlier polled source on a tie
			if (eligible && (!winner.valid || (lv > winner.level))) begin
				winner.valid = 1'b1;
				winner.number = src;
				winner.level = lv;
			end
		end
	end

endmodule // ifp_poll_arbiter
`default_nettype wire

// ===== logic/ifp_service_stack.sv
`timescale 1ns/100ps
`default_nettype none
module ifp_service_stack (
	input wire logic clk, // System clock
	input wire logic rstN, // Synchronised reset, active low
	input wire logic push, // Routine entered
	input wire ifp_pkg::ifp_level_t pushLevel, // Its level
	input wire logic pop, // Return from interrupt
	output logic active, // Some routine in service
	output ifp_pkg::ifp_level_t level // Highest level in service
);
	import ifp_pkg::*;

	logic [IFP_NUM_LVL-1:0] inService_r;
	logic [IFP_NUM_LVL-1:0] inService_nxt;
	logic [IFP_NUM_LVL-1:0] topBit;

	// ----------------------------------------------------------------
	// Nesting mask
	// ----------------------------------------------------------------
	function automatic logic [IFP_NUM_LVL-1:0] highest(input logic [IFP_NUM_LVL-1:0] m);
		logic [IFP_NUM_LVL-1:0] r;
		r = '0;
		for (int i = 0; i < IFP_NUM_LVL; i++) begin
			if (m[i]) begin
				r = '0;
				r[i] = 1'b1;
			end
		end
		return r;
	endfunction

	assign topBit = highest(inService_r);
	assign active = |inService_r;
	assign level = topBit[3] ? 2'h3 : topBit[2] ? 2'h2 : topBit[1] ? 2'h1 : 2'h0;
	// Return clears the most recent, which is always the highest
	assign inService_nxt = (inService_r & ~(pop ? topBit : '0))
		| (push ? (4'h1 << pushLevel) : 4'h0);

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			inService_r <= '0;
		end else begin
			inService_r <= inService_nxt;
		end
	end

	a_push_raises_level: assert property (@(posedge clk) disable iff (!rstN)
		push && !pop |=> active && (level == $past(pushLevel)))
		else $error("Entered routine level not in service");

endmodule // ifp_service_stack
`default_nettype wire

// ===== logic/ifp_interrupt_unit.sv
`timescale 1ns/100ps
`default_nettype none
module ifp_interrupt_unit #(
	parameter logic [15:0] VECTOR_BASE = 16'h0003, // First vector address
	parameter logic [15:0] VECTOR_STRIDE = 16'h0008 // Vector spacing
) (
	input wire logic clk, // System clock, 25 MHz
	input wire logic rst_n, // Asynchronous reset, active low
	input wire ifp_pkg::ifp_byte_t regAddr, // Register address
	input wire ifp_pkg::ifp_byte_t regWdata, // Write data
	input wire logic regWr, // Write strobe
	input wire logic regRd, // Read strobe
	output ifp_pkg::ifp_byte_t regRdata, // Read data, cycle after strobe
	input wire ifp_pkg::ifp_set_s setEvents, // Source event pulses
	input wire ifp_pkg::ifp_outside_s outsideFlags, // Flags held elsewhere
	input wire logic instrBoundary, // Core can take a request
	input wire logic retiDone, // Core returned from a routine
	output ifp_pkg::ifp_req_s request, // Presented request
	output logic forcedLongCall, // Forced call in progress
	output logic [15:0] vectorAddr, // Target of forced call
	output logic ackPulse, // One cycle after a take
	output ifp_pkg::ifp_src_t ackNumber, // Source that was taken
	output logic serviceActive, // Routine in service
	output ifp_pkg::ifp_level_t serviceLevel // Level in service
);
	import ifp_pkg::*;

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	logic rstMeta_r;
	logic rstSync_r;
	logic rstN;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rstMeta_r <= 1'b0;
			rstSync_r <= 1'b0;
		end else begin
			rstMeta_r <= 1'b1;
			rstSync_r <= rstMeta_r;
		end
	end

	assign rstN = rstSync_r;

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	logic [5:0] prioLow_r;
	logic [5:0] prioHigh_r;
	ifp_byte_t flagsFour_r;
	ifp_byte_t flagsFive_r;
	ifp_byte_t regRdata_r;
	ifp_req_s request_r;
	logic [2:0] callCount_r;
	logic [15:0] vectorAddr_r;
	logic ackPulse_r;
	ifp_src_t ackNumber_r;

	logic [5:0] prioLow_nxt;
	logic [5:0] prioHigh_nxt;
	ifp_byte_t flagsFour_nxt;
	ifp_byte_t flagsFive_nxt;
	ifp_byte_t readMux;
	ifp_req_s request_nxt;
	logic [2:0] callCount_nxt;

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	wire hitLow = regAddr == IFP_OFS_PRIO_LOW;
	wire hitHigh = regAddr == IFP_OFS_PRIO_HIGH;
	wire hitFour = regAddr == IFP_OFS_FLAGS_FOUR;
	wire hitFive = regAddr == IFP_OFS_FLAGS_FIVE;
	wire wrLow = regWr && hitLow;
	wire wrHigh = regWr && hitHigh;
	wire wrFour = regWr && hitFour;
	wire wrFive = regWr && hitFive;
	wire callIdle = callCount_r == 3'h0;
	wire takeNow = request_r.valid && instrBoundary && callIdle;
	wire ifp_src_t takeNum = request_r.number;

	function automatic logic [15:0] vectorOf(input ifp_src_t n);
		return 16'(VECTOR_BASE + (VECTOR_STRIDE * {11'h000, n}));
	endfunction

	// ----------------------------------------------------------------
	// Flag images
	// ----------------------------------------------------------------
	ifp_byte_t setFour;
	ifp_byte_t setFive;
	ifp_byte_t hwClrFour;

	assign setFour = {setEvents.sleepTimer, 1'b0, setEvents.portZero, setEvents.timerFour,
		setEvents.timerThree, setEvents.timerTwo, setEvents.timerOne,
		setEvents.transferDone};
	assign setFive = {3'h0, setEvents.watchdog, setEvents.portOne, setEvents.serialOneTx,
		setEvents.serialZeroTx, setEvents.portTwo};

	// Only the four timer flags clear on vectoring
	assign hwClrFour = takeNow ? {3'h0, takeNum == IFP_SRC_TIMER4, takeNum == IFP_SRC_TIMER3,
		takeNum == IFP_SRC_TIMER2, takeNum == IFP_SRC_TIMER1, 1'b0} : 8'h00;

	// Event set wins over software or hardware clear
	assign flagsFour_nxt = ((wrFour ? regWdata : (flagsFour_r & ~hwClrFour)) | setFour)
		& IFP_MASK_FLAGS_FOUR;
	assign flagsFive_nxt = ((wrFive ? regWdata : flagsFive_r) | setFive)
		& IFP_MASK_FLAGS_FIVE;
	assign prioLow_nxt = wrLow ? regWdata[5:0] : prioLow_r;
	assign prioHigh_nxt = wrHigh ? regWdata[5:0] : prioHigh_r;

	// ----------------------------------------------------------------
	// Pending vector by source number
	// ----------------------------------------------------------------
	logic [IFP_NUM_SRC-1:0] pending;

	assign pending = {
		flagsFive_r[IFP_BIT_WDOG],
		outsideFlags.radioGeneral,
		flagsFive_r[IFP_BIT_PORT1],
		flagsFive_r[IFP_BIT_STX1],
		flagsFour_r[IFP_BIT_PORT0],
		flagsFour_r[IFP_BIT_TIMER4],
		flagsFour_r[IFP_BIT_TIMER3],
		flagsFour_r[IFP_BIT_TIMER2],
		flagsFour_r[IFP_BIT_TIMER1],
		flagsFour_r[IFP_BIT_XFER],
		flagsFive_r[IFP_BIT_STX0],
		flagsFive_r[IFP_BIT_PORT2],
		flagsFour_r[IFP_BIT_SLEEP],
		outsideFlags.cipher,
		outsideFlags.serialOneRx,
		outsideFlags.serialZeroRx,
		outsideFlags.converter,
		outsideFlags.radioFifoError};

	// ----------------------------------------------------------------
	// Arbitration and nesting
	// ----------------------------------------------------------------
	ifp_req_s arbWin;
	logic stackActive;
	ifp_level_t stackLevel;

	ifp_poll_arbiter u_arbiter (
		.pending(pending),
		.prioHigh(prioHigh_r),
		.prioLow(prioLow_r),
		.serviceActive(stackActive),
		.serviceLevel(stackLevel),
		.winner(arbWin)
	);

	ifp_service_stack u_stack (
		.clk(clk),
		.rstN(rstN),
		.push(takeNow),
		.pushLevel(request_r.level),
		.pop(retiDone && stackActive),
		.active(stackActive),
		.level(stackLevel)
	);

	// Detect cycle registers the winner; nothing new while a call runs
	assign request_nxt = (arbWin.valid && callIdle && !takeNow && !retiDone) ? arbWin : '0;
	assign callCount_nxt = takeNow ? IFP_CALL_LOAD
		: (callIdle ? 3'h0 : 3'(callCount_r - 3'h1));

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	assign readMux = hitLow ? {2'h0, prioLow_r}
		: hitHigh ? {2'h0, prioHigh_r}
		: hitFour ? flagsFour_r
		: hitFive ? flagsFive_r
		: IFP_READ_IDLE;

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			prioLow_r <= IFP_RST_PRIO;
			prioHigh_r <= IFP_RST_PRIO;
			flagsFour_r <= IFP_RST_FLAGS;
			flagsFive_r <= IFP_RST_FLAGS;
		end else begin
			prioLow_r <= prioLow_nxt;
			prioHigh_r <= prioHigh_nxt;
			flagsFour_r <= flagsFour_nxt;
			flagsFive_r <= flagsFive_nxt;
		end
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			regRdata_r <= IFP_READ_IDLE;
			request_r <= '0;
			callCount_r <= 3'h0;
		end else begin
			regRdata_r <= regRd ? readMux : IFP_READ_IDLE;
			request_r <= request_nxt;
			callCount_r <= callCount_nxt;
		end
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			vectorAddr_r <= 16'h0000;
			ackPulse_r <= 1'b0;
			ackNumber_r <= '0;
		end else begin
			vectorAddr_r <= takeNow ? vectorOf(takeNum) : vectorAddr_r;
			ackPulse_r <= takeNow;
			ackNumber_r <= takeNow ? takeNum : ackNumber_r;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign regRdata = regRdata_r;
	assign request = request_r;
	assign forcedLongCall = !callIdle;
	assign vectorAddr = vectorAddr_r;
	assign ackPulse = ackPulse_r;
	assign ackNumber = ackNumber_r;
	assign serviceActive = stackActive;
	assign serviceLevel = stackLevel;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstN);

	sequence s_take;
		takeNow;
	endsequence

	sequence s_call_body;
		forcedLongCall [*6] ##1 !forcedLongCall;
	endsequence

	a_timer_hw_clear: assert property (
		takeNow && (takeNum == IFP_SRC_TIMER1) && !setEvents.timerOne && !wrFour
		|=> !flagsFour_r[IFP_BIT_TIMER1])
		else $error("Timer one flag survived vectoring");

	a_sleep_no_clear: assert property (
		takeNow && !wrFour
		|=> (flagsFour_r[IFP_BIT_SLEEP] || !$past(flagsFour_r[IFP_BIT_SLEEP]))
		&& (flagsFour_r[IFP_BIT_PORT0] || !$past(flagsFour_r[IFP_BIT_PORT0]))
		&& (flagsFour_r[IFP_BIT_XFER] || !$past(flagsFour_r[IFP_BIT_XFER])))
		else $error("Flag without hardware clear dropped by vectoring");

	a_unused_read_zero: assert property (
		(flagsFive_r[7:5] == 3'h0) && (flagsFour_r[6] == 1'b0))
		else $error("Unused flag bit is set");

	a_set_beats_clear: assert property (
		setEvents.timerTwo |=> flagsFour_r[IFP_BIT_TIMER2])
		else $error("Timer two event lost");

	a_read_one_cycle: assert property (
		regRd && hitHigh |=> regRdata == {2'h0, $past(prioHigh_r)})
		else $error("Read data wrong in cycle after strobe");

	a_no_equal_level: assert property (
		request.valid && serviceActive |-> request.level > serviceLevel)
		else $error("Request presented at or below level in service");

	a_detect_next: assert property (
		arbWin.valid && callIdle && !takeNow && !retiDone
		|=> request.valid && (request.number == $past(arbWin.number)))
		else $error("Selected request not presented after detect cycle");

	a_vector_target: assert property (
		s_take |=> vectorAddr == vectorOf($past(takeNum)) && ackPulse)
		else $error("Forced call vector wrong");

	a_call_length: assert property (
		s_take |=> s_call_body)
		else $error("Forced call not six cycles");

	a_flag_held: assert property (
		flagsFive_r[IFP_BIT_WDOG] && !wrFive |=> flagsFive_r[IFP_BIT_WDOG])
		else $error("Watchdog flag dropped without software");

endmodule // ifp_interrupt_unit
`default_nettype wire

// ===== testbench/ifp_core_model.sv
`timescale 1ns/100ps
`default_nettype none
module ifp_core_model (
	input wire logic clk, // System clock
	input wire logic rstN, // Reset, active low
	input wire logic acceptEn, // Bench lets the core take requests
	input wire logic retiCmd, // Bench ends a routine
	output logic instrBoundary, // Core at an instruction edge
	output logic retiDone // Return executed
);
	// ----------------------------------------------------------------
	// Core handshake, one cycle behind the bench
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			instrBoundary <= 1'b0;
			retiDone <= 1'b0;
		end else begin
			instrBoundary <= acceptEn;
			retiDone <= retiCmd;
		end
	end
endmodule // ifp_core_model
`default_nettype wire

// ===== testbench/tb_interrupt_flag_priority_unit.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin \
	cmp_count++; \
	if ((got) !== (exp)) begin \
		mismatches++; \
		$display("unexpected at %0t: got %h exp %h", $time, (got), (exp)); \
	end \
end
module tb_interrupt_flag_priority_unit;
	import ifp_pkg::*;
	localparam logic [15:0] VB = 16'h0003;
	localparam logic [15:0] VS = 16'h0008;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	ifp_byte_t regAddr = 8'h00;
	ifp_byte_t regWdata = 8'h00;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	ifp_byte_t regRdata;
	ifp_set_s setEvents = '0;
	ifp_outside_s outsideFlags = '0;
	logic instrBoundary;
	logic retiDone;
	logic acceptEn = 1'b0;
	logic retiCmd = 1'b0;
	ifp_req_s request;
	logic forcedLongCall;
	logic [15:0] vectorAddr;
	logic ackPulse;
	ifp_src_t ackNumber;
	logic serviceActive;
	ifp_level_t serviceLevel;
	int mismatches = 0;
	int cmp_count = 0;
	ifp_byte_t regs [4] = '{IFP_OFS_PRIO_LOW, IFP_OFS_PRIO_HIGH, IFP_OFS_FLAGS_FOUR,
		IFP_OFS_FLAGS_FIVE};
	ifp_byte_t masks [4] = '{8'h3f, 8'h3f, 8'hbf, 8'h1f};
	ifp_src_t srcNum [12] = '{5'h06, 5'h07, 5'h0e, 5'h0f, 5'h11, 5'h08, 5'h09, 5'h0a, 5'h0b,
		5'h0c, 5'h0d, 5'h05};
	int grp [12] = '{1, 2, 3, 4, 5, 0, 1, 2, 3, 4, 5, 5};

	always #20 clk = ~clk;

	ifp_interrupt_unit #(.VECTOR_BASE(VB), .VECTOR_STRIDE(VS)) dut (.clk(clk), .rst_n(rst_n),
		.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .setEvents(setEvents), .outsideFlags(outsideFlags),
		.instrBoundary(instrBoundary), .retiDone(retiDone), .request(request),
		.forcedLongCall(forcedLongCall), .vectorAddr(vectorAddr), .ackPulse(ackPulse),
		.ackNumber(ackNumber), .serviceActive(serviceActive), .serviceLevel(serviceLevel));

	ifp_core_model core (.clk(clk), .rstN(rst_n), .acceptEn(acceptEn), .retiCmd(retiCmd),
		.instrBoundary(instrBoundary), .retiDone(retiDone));

	// ----------------------------------------------------------------
	// Bus and event tasks
	// ----------------------------------------------------------------
	task automatic wr(input ifp_byte_t a, input ifp_byte_t d);
		@(posedge clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
	endtask

	task automatic rd(input ifp_byte_t a, input ifp_byte_t exp);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		#1;
		`CHK(regRdata, exp)
	endtask

	task automatic pulse(input logic [11:0] ev);
		@(posedge clk);
		setEvents <= ifp_set_s'(ev);
		@(posedge clk);
		setEvents <= '0;
	endtask

	task automatic reti();
		@(posedge clk);
		retiCmd <= 1'b1;
		@(posedge clk);
		retiCmd <= 1'b0;
	endtask

	task automatic expReq(input ifp_src_t n, input ifp_level_t lv, input logic v);
		repeat (3) @(posedge clk);
		#1;
		if (v) `CHK(request, ifp_req_s'{1'b1, n, lv}) else `CHK(request.valid, 1'b0)
	endtask

	// Lets the core take one request, then checks the forced call
	task automatic take(input ifp_src_t n, input ifp_level_t lv);
		int cnt;
		@(posedge clk);
		acceptEn <= 1'b1;
		cnt = 0;
		while (forcedLongCall !== 1'b1 && cnt < 20) begin
			@(negedge clk);
			cnt++;
		end
		`CHK(ackPulse, 1'b1)
		`CHK(ackNumber, n)
		`CHK(vectorAddr, 16'(VB + VS * n))
		`CHK(serviceLevel, lv)
		@(posedge clk);
		acceptEn <= 1'b0;
		cnt = 1;
		do begin
			@(negedge clk);
			if (forcedLongCall === 1'b1) cnt++;
		end while (forcedLongCall === 1'b1 && cnt < 20);
		`CHK(cnt, 32'd6)
	endtask

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		ifp_byte_t exp;
		ifp_byte_t gm;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		for (int i = 0; i < 4; i++) rd(regs[i], 8'h00);
		for (int i = 0; i < 4; i++) wr(regs[i], 8'hff);
		for (int i = 0; i < 4; i++) rd(regs[i], masks[i]);
		wr(8'h10, 8'h55);
		rd(8'h10, 8'h00);
		for (int i = 0; i < 4; i++) wr(regs[i], 8'h00);
		expReq(5'h00, 2'h0, 1'b0);
		for (int i = 0; i < 12; i++) begin
			pulse(12'h001 << i);
			exp = (i == 11) ? 8'h80 : (i > 4) ? 8'h01 << (i - 5) : 8'h01 << i;
			rd((i > 4) ? IFP_OFS_FLAGS_FOUR : IFP_OFS_FLAGS_FIVE, exp);
			gm = 8'h01 << grp[i];
			for (int lv = 0; lv < 4; lv++) begin
				wr(IFP_OFS_PRIO_HIGH, lv[1] ? gm : 8'h00);
				wr(IFP_OFS_PRIO_LOW, lv[0] ? gm : 8'h00);
				expReq(srcNum[i], 2'(lv), 1'b1);
			end
			for (int k = 0; k < 4; k++) wr(regs[k], 8'h00);
			expReq(5'h00, 2'h0, 1'b0);
		end
		pulse(12'h060);
		expReq(IFP_SRC_XFER, 2'h0, 1'b1);
		@(posedge clk);
		outsideFlags <= ifp_outside_s'(6'h20);
		expReq(IFP_SRC_RADIO_FIFO_ERROR_SOURCE, 2'h0, 1'b1);
		@(posedge clk);
		outsideFlags <= '0;
		wr(IFP_OFS_FLAGS_FOUR, 8'h02);
		expReq(IFP_SRC_TIMER1, 2'h0, 1'b1);
		wr(IFP_OFS_PRIO_LOW, 8'h02);
		expReq(IFP_SRC_TIMER1, 2'h1, 1'b1);
		take(IFP_SRC_TIMER1, 2'h1);
		rd(IFP_OFS_FLAGS_FOUR, 8'h00);
		wr(IFP_OFS_PRIO_LOW, 8'h03);
		pulse(12'h020);
		expReq(5'h00, 2'h0, 1'b0);
		wr(IFP_OFS_PRIO_HIGH, 8'h01);
		expReq(IFP_SRC_XFER, 2'h3, 1'b1);
		take(IFP_SRC_XFER, 2'h3);
		rd(IFP_OFS_FLAGS_FOUR, 8'h01);
		reti();
		expReq(IFP_SRC_XFER, 2'h3, 1'b1);
		`CHK(serviceLevel, 2'h1)
		wr(IFP_OFS_FLAGS_FOUR, 8'h00);
		reti();
		expReq(5'h00, 2'h0, 1'b0);
		`CHK(serviceActive, 1'b0)
		tally_and_finish();
	end

	initial begin
		#800000;
		mismatches++;
		tally_and_finish();
	end
endmodule // tb_interrupt_flag_priority_unit
`default_nettype wire
